//--- rtl/hrx_rx_err.sv
// Single-channel HDLC receiver with error handling and descriptor DMA.
// Assumes serial bits arrive synchronous to pclk with a one-cycle strobe,
// and a shared-memory slave that answers each request with mem_ack.
`timescale 1ns/1ns

// How it works
// - Flag a check-sequence error when the computed CRC residue is wrong.
// - Check-sequence error queues a receive interrupt entry unless masked.
// - All bytes of a check-sequence-error message reach memory first.
// - Check-sequence error returns descriptor to host unless status writes inhibited.
// - Flag alignment error when destuffed length is not a multiple of 8.
// - Alignment error queues a receive interrupt entry unless masked.
// - Alignment error stores every complete byte, then returns descriptor unless inhibited.
// - A 0 followed by seven 1s aborts the message in progress.
// - Abort queues a receive interrupt entry unless masked.
// - Bytes received before an abort stay in memory.
// - Abort returns descriptor to host with abort code unless inhibited.
// - After an error the next-message pointer is read from the descriptor.
// - After an error the receiver hunts for the next opening flag.
// - Descriptor ownership is confirmed before new data is written.
module hrx_rx_err (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial receive link
    input wire logic rx_bit,
    input wire logic rx_bit_en,
    // Shared-memory master
    output hrx_pkg::hrx_mreq_t mem_o,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    // Interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    typedef enum logic {B_HUNT, B_FRAME} hrx_framer_t;
    typedef enum logic [2:0] {D_IDLE, D_POLL, D_READY, D_WDATA, D_NEXT, D_STAT, D_IRQQ}
        hrx_dma_t;

    hrx_framer_t framer_ff;
    hrx_dma_t dma_ff;
    logic [2:0] ctrl_ff;
    logic [31:0] desc_ff, next_ff, buf_ff, iq_ff;
    logic [3:0] ista_ff, imask_ff;
    logic [31:0] prdata_ff;
    logic pready_ff, pslverr_ff, irq_ff;
    hrx_pkg::hrx_mreq_t mem_ff;
    logic [7:0] raw_ff, sh_ff, byte_ff;
    logic [2:0] ones_ff, dly_n_ff, bitpos_ff;
    logic [5:0] dly_ff;
    logic [15:0] crc_ff, nbytes_ff, cnt_ff, end_cnt_ff;
    logic byte_vld_ff, end_vld_ff;
    logic [2:0] end_err_ff, err_ff;

    function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
        crc_step = (c[0] ^ b) ? ((c >> 1) ^ hrx_pkg::CRC_POLY) : (c >> 1);
    endfunction

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire apb_setup = psel && penable && !pready_ff;
    wire apb_done = psel && penable && pready_ff;
    wire apb_wr = apb_done && pwrite;
    wire hit_ctrl = paddr == hrx_pkg::REG_CTRL;
    wire hit_desc = paddr == hrx_pkg::REG_DESC;
    wire hit_iq = paddr == hrx_pkg::REG_IQ_BASE;
    wire hit_ista = paddr == hrx_pkg::REG_IRQ_STAT;
    wire hit_imask = paddr == hrx_pkg::REG_IRQ_MASK;
    wire hit_state = paddr == hrx_pkg::REG_STATE;
    wire hit_any = hit_ctrl || hit_desc || hit_iq || hit_ista || hit_imask || hit_state;
    wire [31:0] state_word = {13'h0, end_vld_ff, byte_vld_ff, framer_ff == B_FRAME,
                              nbytes_ff};
    wire [31:0] rd_word = hit_ctrl ? {29'h0, ctrl_ff} :
                          hit_desc ? desc_ff :
                          hit_iq ? iq_ff :
                          hit_ista ? {28'h0, ista_ff} :
                          hit_imask ? {28'h0, imask_ff} :
                          hit_state ? state_word : 32'h0;
    wire en = ctrl_ff[hrx_pkg::CTRL_EN_BIT];
    wire message_error_irq_mask = ctrl_ff[hrx_pkg::CTRL_MSG_MASK_BIT];
    wire rx_status_write_inhibit = ctrl_ff[hrx_pkg::CTRL_INHIBIT_BIT];

    // Wait state of one cycle keeps prdata on a flop before pready rises
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup && !hit_any;
            if (apb_setup) begin
                prdata_ff <= pwrite ? 32'h0 : rd_word;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= hrx_pkg::CTRL_RST;
            iq_ff <= 32'h0;
            imask_ff <= hrx_pkg::IRQ_MASK_RST;
        end else if (apb_wr) begin
            if (hit_ctrl) ctrl_ff <= pwdata[2:0];
            if (hit_iq) iq_ff <= pwdata;
            if (hit_imask) imask_ff <= pwdata[3:0];
        end else if (dma_ff == D_IRQQ && mem_ack) begin
            iq_ff <= iq_ff + hrx_pkg::WORD_STEP;
        end
    end

    // ------------------------------------------------------------
    // Bit-level processor
    // ------------------------------------------------------------
    wire bit_go = rx_bit_en && en;
    wire [7:0] raw_n = {raw_ff[6:0], rx_bit};
    wire flag_hit = raw_n == hrx_pkg::FLAG_PAT;
    wire abort_hit = raw_n == hrx_pkg::ABORT_PAT;
    wire stuffed = (ones_ff == hrx_pkg::STUFF_RUN) && !rx_bit;
    wire run_bit = (ones_ff >= hrx_pkg::STUFF_RUN) && rx_bit;
    wire data_bit = !stuffed && !run_bit;
    wire commit = data_bit && (dly_n_ff == hrx_pkg::DLY_DEPTH);
    wire cbit = dly_ff[5];
    wire any_rx = (nbytes_ff != 16'h0) || (bitpos_ff != 3'h0);
    wire [2:0] close_err = (bitpos_ff != 3'h0) ? hrx_pkg::ERR_ALIGN :
                           (crc_ff != hrx_pkg::CRC_GOOD) ? hrx_pkg::ERR_FCS :
                           hrx_pkg::ERR_NONE;
    wire in_frame = framer_ff == B_FRAME;
    wire msg_end = bit_go && in_frame && (flag_hit || abort_hit) && any_rx;
    wire [2:0] end_code = abort_hit ? hrx_pkg::ERR_ABORT : close_err;
    wire byte_done = bit_go && in_frame && !flag_hit && !abort_hit && commit &&
                     (bitpos_ff == 3'h7);
    wire byte_take = dma_ff == D_WDATA && mem_ack;
    wire end_take = dma_ff == D_NEXT && mem_ack;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            framer_ff <= B_HUNT;
            raw_ff <= 8'h0;
            ones_ff <= 3'h0;
        end else if (!en) begin
            framer_ff <= B_HUNT;
        end else if (bit_go) begin
            raw_ff <= raw_n;
            ones_ff <= !rx_bit ? 3'h0 : (ones_ff == 3'h7) ? ones_ff : ones_ff + 3'h1;
            if (abort_hit || (flag_hit && end_code != hrx_pkg::ERR_NONE && any_rx)) begin
                framer_ff <= B_HUNT;
            end else if (flag_hit) begin
                framer_ff <= B_FRAME;
            end
        end
    end

    // Frame accumulation: six-bit delay hides the closing flag from the CRC
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dly_ff <= 6'h0;
            dly_n_ff <= 3'h0;
            crc_ff <= hrx_pkg::CRC_INIT;
            sh_ff <= 8'h0;
            bitpos_ff <= 3'h0;
            nbytes_ff <= 16'h0;
        end else if (bit_go && (flag_hit || abort_hit || !in_frame)) begin
            dly_n_ff <= 3'h0;
            crc_ff <= hrx_pkg::CRC_INIT;
            bitpos_ff <= 3'h0;
            nbytes_ff <= 16'h0;
        end else if (bit_go && data_bit) begin
            dly_ff <= {dly_ff[4:0], rx_bit};
            if (!commit) dly_n_ff <= dly_n_ff + 3'h1;
            if (commit) begin
                crc_ff <= crc_step(crc_ff, cbit);
                sh_ff <= {cbit, sh_ff[7:1]};
                bitpos_ff <= bitpos_ff + 3'h1;
                if (bitpos_ff == 3'h7) nbytes_ff <= nbytes_ff + 16'h1;
            end
        end
    end

    // Hand-off to the DMA side; a new event wins over a same-cycle take
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            byte_vld_ff <= 1'b0;
            byte_ff <= 8'h0;
            end_vld_ff <= 1'b0;
            end_err_ff <= hrx_pkg::ERR_NONE;
            end_cnt_ff <= 16'h0;
        end else begin
            if (byte_done) begin
                byte_vld_ff <= 1'b1;
                byte_ff <= {cbit, sh_ff[7:1]};
            end else if (byte_take) begin
                byte_vld_ff <= 1'b0;
            end
            if (msg_end) begin
                end_vld_ff <= 1'b1;
                end_err_ff <= end_code;
                end_cnt_ff <= nbytes_ff;
            end else if (end_take) begin
                end_vld_ff <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // DMA controller
    // ------------------------------------------------------------
    wire owned = mem_rdata[hrx_pkg::OWNER_BIT];
    wire desc_wr = apb_wr && hit_desc;
    hrx_pkg::hrx_bstat_t bstat;
    hrx_pkg::hrx_iqe_t iqe;
    assign bstat = '{owner: hrx_pkg::OWNER_HOST, rsvd: 12'h0, err: err_ff, count: cnt_ff};
    assign iqe = '{dir: hrx_pkg::DIR_RX, rsvd: 28'h0, err: err_ff};
    wire want_iq = err_ff != hrx_pkg::ERR_NONE && !message_error_irq_mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dma_ff <= D_IDLE;
            mem_ff <= '0;
            desc_ff <= 32'h0;
            next_ff <= 32'h0;
            buf_ff <= 32'h0;
            err_ff <= hrx_pkg::ERR_NONE;
            cnt_ff <= 16'h0;
        end else if (desc_wr) begin
            desc_ff <= pwdata;
            dma_ff <= D_IDLE;
            mem_ff <= '0;
        end else begin
            unique case (dma_ff)
                D_IDLE: if (en) begin
                    dma_ff <= D_POLL;
                    mem_ff <= '{req: 1'b1, we: 1'b0, addr: desc_ff, wdata: 32'h0};
                end
                D_POLL: if (mem_ack) begin
                    mem_ff.req <= 1'b0;
                    buf_ff <= {1'b0, mem_rdata[30:0]};
                    dma_ff <= owned ? D_READY : D_IDLE;
                end
                D_READY: if (byte_vld_ff) begin
                    dma_ff <= D_WDATA;
                    mem_ff <= '{req: 1'b1, we: 1'b1, addr: buf_ff, wdata: {24'h0, byte_ff}};
                end else if (end_vld_ff) begin
                    dma_ff <= D_NEXT;
                    err_ff <= end_err_ff;
                    cnt_ff <= end_cnt_ff;
                    mem_ff <= '{req: 1'b1, we: 1'b0, addr: desc_ff + hrx_pkg::DESC_NEXT_OFS,
                                wdata: 32'h0};
                end
                D_WDATA: if (mem_ack) begin
                    mem_ff.req <= 1'b0;
                    buf_ff <= buf_ff + 32'h1;
                    dma_ff <= D_READY;
                end
                D_NEXT: if (mem_ack) begin
                    next_ff <= mem_rdata;
                    dma_ff <= rx_status_write_inhibit ? D_IRQQ : D_STAT;
                    if (rx_status_write_inhibit) begin
                        mem_ff <= '{req: want_iq, we: 1'b1, addr: iq_ff, wdata: iqe};
                    end else begin
                        mem_ff <= '{req: 1'b1, we: 1'b1, addr: desc_ff + hrx_pkg::DESC_STAT_OFS,
                                    wdata: bstat};
                    end
                end
                D_STAT: if (mem_ack) begin
                    dma_ff <= D_IRQQ;
                    mem_ff <= '{req: want_iq, we: 1'b1, addr: iq_ff, wdata: iqe};
                end
                D_IRQQ: if (mem_ack || !mem_ff.req) begin
                    mem_ff.req <= 1'b0;
                    desc_ff <= next_ff;
                    dma_ff <= D_IDLE;
                end
                default: dma_ff <= D_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Interrupt status, set wins over write-one-to-clear
    // ------------------------------------------------------------
    wire [3:0] ev = {msg_end && end_code == hrx_pkg::ERR_NONE,
                     msg_end && end_code == hrx_pkg::ERR_ABORT,
                     msg_end && end_code == hrx_pkg::ERR_ALIGN,
                     msg_end && end_code == hrx_pkg::ERR_FCS};
    wire [3:0] clr = (apb_wr && hit_ista) ? pwdata[3:0] : 4'h0;
    wire [3:0] nxt_ista = (ista_ff & ~clr) | ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ista_ff <= 4'h0;
            irq_ff <= 1'b0;
        end else begin
            ista_ff <= nxt_ista;
            irq_ff <= |(nxt_ista & imask_ff);
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign mem_o = mem_ff;
    assign irq = irq_ff;
endmodule

//--- rtl/hrx_pkg.sv
// Shared constants and carriers for the HDLC receive error handler.
// Assumes one 25 MHz APB clock and a 32-bit shared-memory master port.
package hrx_pkg;
    // ------------------------------------------------------------
    // Bit-level patterns and check sequence
    // ------------------------------------------------------------
    localparam logic [7:0] FLAG_PAT = 8'h7e;
    localparam logic [7:0] ABORT_PAT = 8'h7f;
    localparam logic [2:0] STUFF_RUN = 3'h5;
    localparam logic [2:0] DLY_DEPTH = 3'h6;
    localparam logic [15:0] CRC_INIT = 16'hffff;
    localparam logic [15:0] CRC_POLY = 16'h8408;
    localparam logic [15:0] CRC_GOOD = 16'hf0b8;

    // ------------------------------------------------------------
    // APB register offsets and fields
    // ------------------------------------------------------------
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_DESC = 8'h04;
    localparam logic [7:0] REG_IQ_BASE = 8'h08;
    localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
    localparam logic [7:0] REG_IRQ_MASK = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MSG_MASK_BIT = 1;
    localparam int CTRL_INHIBIT_BIT = 2;
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;
    localparam int IRQ_FCS = 0;
    localparam int IRQ_ALIGN = 1;
    localparam int IRQ_ABORT = 2;
    localparam int IRQ_EOM = 3;

    // ------------------------------------------------------------
    // Error codes, descriptor layout
    // ------------------------------------------------------------
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_FCS = 3'h1;
    localparam logic [2:0] ERR_ALIGN = 3'h2;
    localparam logic [2:0] ERR_ABORT = 3'h3;
    localparam logic [31:0] DESC_CTL_OFS = 32'h0;
    localparam logic [31:0] DESC_NEXT_OFS = 32'h4;
    localparam logic [31:0] DESC_STAT_OFS = 32'h8;
    localparam int OWNER_BIT = 31;
    localparam logic OWNER_HOST = 1'b0;
    localparam logic DIR_RX = 1'b0;
    localparam logic [31:0] WORD_STEP = 32'h4;

    typedef struct packed {
        logic owner;
        logic [11:0] rsvd;
        logic [2:0] err;
        logic [15:0] count;
    } hrx_bstat_t;

    typedef struct packed {
        logic dir;
        logic [27:0] rsvd;
        logic [2:0] err;
    } hrx_iqe_t;

    typedef struct packed {
        logic req;
        logic we;
        logic [31:0] addr;
        logic [31:0] wdata;
    } hrx_mreq_t;
endpackage

//--- test/hrx_rx_err_sva.sv
// Port assertions for the HDLC receive error handler.
// Assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/1ns
module hrx_rx_err_sva (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Memory master and interrupt
    input wire hrx_pkg::hrx_mreq_t mem_o,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    input wire logic irq
);
    // ----------------
    // Helper state
    // ----------------
    logic [3:0] mask_ff;
    logic own_ff;
    logic [31:0] poll_ff;
    wire mask_wr = psel && penable && pready && pwrite && paddr == hrx_pkg::REG_IRQ_MASK;
    wire rd_ack = mem_o.req && !mem_o.we && mem_ack;
    wire own_rd = rd_ack && mem_rdata[hrx_pkg::OWNER_BIT];
    // Any read but the next pointer is a fresh poll; host owner there ends ownership
    wire own_lost = rd_ack && !mem_rdata[hrx_pkg::OWNER_BIT] &&
                    mem_o.addr != poll_ff + hrx_pkg::DESC_NEXT_OFS;
    wire [12:0] wr_top = mem_o.wdata[31:19];
    wire mapped = paddr[1:0] == 2'h0 && paddr <= hrx_pkg::REG_STATE;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= hrx_pkg::IRQ_MASK_RST;
            own_ff <= 1'b0;
            poll_ff <= 32'h0;
        end else begin
            mask_ff <= mask_wr ? pwdata[3:0] : mask_ff;
            own_ff <= own_rd || (own_ff && !own_lost);
            if (own_rd) begin
                poll_ff <= mem_o.addr;
            end
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // ----------------
    // Assertions
    // ----------------
    apb_answer_a: assert property (psel && penable && !pready |=> pready)
        else $error("apb access not answered in one cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    unmapped_err_a: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    err_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("unmapped read returned data");
    mem_hold_a: assert property (mem_o.req && !mem_ack |=> mem_o.req && $stable(mem_o))
        else $error("memory request changed before ack");
    wr_format_a: assert property (mem_o.req && mem_o.we |-> wr_top == 13'h0)
        else $error("memory write with device owner or bad field");
    own_first_a: assert property (mem_o.req && mem_o.we |-> own_ff)
        else $error("memory write before any owned descriptor");
    irq_mask_a: assert property (irq |-> (mask_ff | $past(mask_ff) | $past(mask_ff, 2)) != 4'h0)
        else $error("irq high with all events masked");
    cover property (mem_o.req && mem_o.we && mem_ack);
    cover property (pready && pslverr);
    cover property ($rose(irq));
endmodule

//--- test/hrx_mem_model.sv
// Shared-memory slave for the DMA port, one word per byte address.
// Assumes addresses below 8 KiB; the bench sets the answer latency.
`timescale 1ns/1ns
module hrx_mem_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // DMA request and answer
    input wire hrx_pkg::hrx_mreq_t mem_o,
    input wire logic [3:0] delay,
    output logic mem_ack,
    output logic [31:0] mem_rdata
);
    logic [31:0] mem [0:8191];
    logic [3:0] wait_ff;
    wire go = mem_o.req && !mem_ack && wait_ff >= delay;
    // Plain always: the bench also loads descriptors into mem.
    // Read data toggles outside the ack so a stale word never looks valid.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_ff <= 4'h0;
            mem_ack <= 1'b0;
            mem_rdata <= 32'h0;
        end else begin
            mem_ack <= go;
            wait_ff <= (mem_o.req && !mem_ack && !go) ? wait_ff + 4'h1 : 4'h0;
            mem_rdata <= go ? mem[mem_o.addr[12:0]] : ~mem_rdata;
            if (go && mem_o.we) begin
                mem[mem_o.addr[12:0]] <= mem_o.wdata;
            end
        end
    end
endmodule

//--- test/test_hrx_rx_err.sv
// Bench for the receive error handler: APB host, serial source, memory.
// Assumes bits spaced eight clocks apart and an answering memory model.
`timescale 1ns/1ns
module test_hrx_rx_err;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_bit, rx_bit_en;
    logic mem_ack, irq, sl;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, mem_rdata, rd, last_rd;
    logic [3:0] delay;
    hrx_pkg::hrx_mreq_t mem_o;
    int err_count, check_count, ones;
    logic [7:0] q[$];
    localparam logic [31:0] SENT = 32'hdead_beef;
    hrx_rx_err dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .rx_bit, .rx_bit_en, .mem_o, .mem_ack, .mem_rdata, .irq);
    hrx_mem_model mem_m (.pclk, .presetn, .mem_o, .delay, .mem_ack, .mem_rdata);
    always @(posedge pclk) begin
        if (mem_o.req && !mem_o.we && mem_ack) begin
            last_rd <= mem_o.addr;
        end
    end
    // ----------------
    // Tasks
    // ----------------
    task automatic conclude();
        if (err_count == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(string what, logic [31:0] exp, logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20 && pready !== 1'b1; n++) begin
            @(posedge pclk);
        end
        rd = prdata;
        sl = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        check("apb ready", 32'h1, {31'h0, pready});
        if (pready !== 1'b1) conclude();
    endtask
    task automatic wait_rd(input logic [31:0] a);
        for (int n = 0; n < 4000 && last_rd !== a; n++) begin
            @(posedge pclk);
        end
        check("descriptor poll", a, last_rd);
        if (last_rd !== a) conclude();
    endtask
    task automatic put_bit(input logic b);
        @(posedge pclk);
        rx_bit <= b;
        rx_bit_en <= 1'b1;
        @(posedge pclk);
        rx_bit_en <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    // Stuffed data bits, LSB first; raw mode for flags and the abort run
    task automatic put(input logic [7:0] v, input int n, input logic raw);
        for (int i = 0; i < n; i++) begin
            put_bit(v[i]);
            ones = v[i] ? ones + 1 : 0;
            if (ones == 5 && !raw) begin
                put_bit(1'b0);
                ones = 0;
            end
        end
        ones = raw ? 0 : ones;
    endtask
    task automatic frame(input logic good, input int extra, input logic abort);
        logic [15:0] c;
        c = hrx_pkg::CRC_INIT;
        foreach (q[k]) begin
            put(q[k], 8, 1'b0);
            for (int i = 0; i < 8; i++) begin
                c = (c[0] ^ q[k][i]) ? ((c >> 1) ^ hrx_pkg::CRC_POLY) : (c >> 1);
            end
        end
        c = ~c ^ {15'h0, !good};
        if (abort) begin
            put(8'hfe, 8, 1'b1);
        end else begin
            put(c[7:0], 8, 1'b0);
            put(c[15:8], 8, 1'b0);
            put(8'h02, extra, 1'b0);
            put(hrx_pkg::FLAG_PAT, 8, 1'b1);
        end
    endtask
    task automatic chk_frame(input int k, input logic [2:0] e, input int n, input int iq);
        foreach (q[i]) check("buffer byte", {24'h0, q[i]}, mem_m.mem[32'h1000 + k * 256 + i]);
        check("buffer status", {hrx_pkg::OWNER_HOST, 12'h0, e, n[15:0]}, mem_m.mem[264 + 16 * k]);
        if (iq != 0) check("queue entry", {hrx_pkg::DIR_RX, 28'h0, e}, mem_m.mem[iq]);
    endtask
    // ----------------
    // Sequence
    // ----------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        {presetn, psel, penable, pwrite, rx_bit_en, paddr, pwdata, delay} = '0;
        {err_count, check_count, ones} = '0;
        rx_bit = 1'b1;
        for (int i = 0; i < 8192; i++) mem_m.mem[i] = SENT;
        for (int k = 0; k < 7; k++) begin
            mem_m.mem[256 + 16 * k] = (k < 6 ? 32'h8000_0000 : 32'h0) | (32'h1000 + 256 * k);
            mem_m.mem[260 + 16 * k] = 32'h110 + 16 * k;
        end
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, hrx_pkg::REG_CTRL, 32'h0);
        check("ctrl reset", {29'h0, hrx_pkg::CTRL_RST}, rd);
        apb(1'b0, hrx_pkg::REG_IRQ_MASK, 32'h0);
        check("mask reset", {28'h0, hrx_pkg::IRQ_MASK_RST}, rd);
        apb(1'b1, 8'h18, 32'hffff_ffff);
        check("unmapped error", 32'h1, {31'h0, sl});
        apb(1'b0, 8'h18, 32'h0);
        check("unmapped read", 32'h0, rd);
        apb(1'b1, hrx_pkg::REG_DESC, 32'h100);
        apb(1'b1, hrx_pkg::REG_IQ_BASE, 32'h300);
        apb(1'b1, hrx_pkg::REG_IRQ_MASK, 32'hf);
        apb(1'b1, hrx_pkg::REG_CTRL, 32'h1);
        put(hrx_pkg::FLAG_PAT, 8, 1'b1);
        q = '{8'h5a};
        frame(1'b1, 0, 1'b0);
        wait_rd(32'h110);
        chk_frame(0, hrx_pkg::ERR_NONE, 3, 0);
        q = '{8'hc3, 8'h3e};
        frame(1'b0, 0, 1'b0);
        wait_rd(32'h120);
        chk_frame(1, hrx_pkg::ERR_FCS, 4, 32'h300);
        delay <= 4'h3;
        put(hrx_pkg::FLAG_PAT, 8, 1'b1);
        q = '{8'h81};
        frame(1'b1, 3, 1'b0);
        wait_rd(32'h130);
        chk_frame(2, hrx_pkg::ERR_ALIGN, 3, 32'h304);
        put(hrx_pkg::FLAG_PAT, 8, 1'b1);
        q = '{8'h11, 8'hff};
        frame(1'b1, 0, 1'b1);
        put(hrx_pkg::FLAG_PAT, 8, 1'b1);
        wait_rd(32'h140);
        chk_frame(3, hrx_pkg::ERR_ABORT, 2, 32'h308);
        q = '{8'h7e};
        frame(1'b1, 0, 1'b0);
        wait_rd(32'h150);
        chk_frame(4, hrx_pkg::ERR_NONE, 3, 0);
        apb(1'b1, hrx_pkg::REG_CTRL, 32'h7);
        q = '{8'h42};
        frame(1'b0, 0, 1'b0);
        wait_rd(32'h160);
        check("kept byte", 32'h42, mem_m.mem[32'h1500]);
        check("inhibited status", SENT, mem_m.mem[32'h158]);
        check("masked entry", SENT, mem_m.mem[32'h30c]);
        put(hrx_pkg::FLAG_PAT, 8, 1'b1);
        q = '{8'h99};
        frame(1'b1, 0, 1'b0);
        check("unowned buffer", SENT, mem_m.mem[32'h1600]);
        check("unowned poll", 32'h160, last_rd);
        apb(1'b0, hrx_pkg::REG_IRQ_STAT, 32'h0);
        check("event status", 32'hf, rd);
        check("irq raised", 32'h1, {31'h0, irq});
        apb(1'b1, hrx_pkg::REG_IRQ_MASK, 32'h0);
        apb(1'b0, hrx_pkg::REG_IRQ_STAT, 32'h0);
        check("irq masked", 32'h0, {31'h0, irq});
        apb(1'b1, hrx_pkg::REG_IRQ_MASK, 32'h1);
        apb(1'b1, hrx_pkg::REG_IRQ_STAT, 32'h1);
        apb(1'b0, hrx_pkg::REG_IRQ_STAT, 32'h0);
        check("status cleared", 32'he, rd);
        check("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b0, hrx_pkg::REG_IQ_BASE, 32'h0);
        check("queue pointer", 32'h30c, rd);
        apb(1'b0, hrx_pkg::REG_DESC, 32'h0);
        check("descriptor reg", 32'h160, rd);
        apb(1'b0, hrx_pkg::REG_STATE, 32'h0);
        check("state word", 32'h0007_0000, rd);
        conclude();
    end
endmodule
bind hrx_rx_err hrx_rx_err_sva chk (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .mem_o, .mem_ack, .mem_rdata, .irq);
